/* logic/dcae_pkg.sv */
package dcae_pkg;

  // channel count and index width
  localparam int NCH = 8;
  localparam int CHW = 3;

  // register byte offsets
  localparam logic [11:0] A_CTRL   = 12'h000;
  localparam logic [11:0] A_STATUS = 12'h004;
  localparam logic [11:0] A_DBASE  = 12'h008;
  localparam logic [11:0] A_SWTRIG = 12'h00C;
  localparam logic [11:0] A_CHCFG  = 12'h020;

  // field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CFG_EN_BIT  = 0;
  localparam int CFG_PRI_LSB = 1;
  localparam int CFG_PRE_BIT = 3;
  localparam int CFG_BUF_BIT = 4;
  localparam int CFG_IDX_LSB = 8;
  localparam int STA_BSY_BIT = 0;
  localparam int STA_ACT_LSB = 4;
  localparam int STA_PND_LSB = 8;
  localparam int STA_RES_LSB = 16;

  // reset values
  localparam logic        CTRL_RST  = 1'b0;
  localparam logic [31:0] DBASE_RST = 32'h0000_0000;

  // descriptor layout in memory: four words, 16 bytes apart
  localparam logic [1:0] DESC_LAST_WORD = 2'h3;
  localparam int         DESC_SHIFT     = 4;
  localparam logic [31:0] WORD_STEP     = 32'h0000_0004;

  // element width codes
  localparam logic [1:0] W_BYTE = 2'h0;
  localparam logic [1:0] W_HALF = 2'h1;
  localparam logic [1:0] W_WORD = 2'h2;

  // per-channel settings
  typedef struct packed {
    logic [7:0] idx;
    logic       buff;
    logic       pre;
    logic [1:0] prio;
    logic       en;
  } dcae_chcfg_s;

  // descriptor word 0
  typedef struct packed {
    logic [7:0] y_last;
    logic [7:0] x_last;
    logic [7:0] next_desc_index;
    logic [2:0] rsvd;
    logic       chain;
    logic [1:0] dst_w;
    logic [1:0] src_w;
  } dcae_desc_s;

  // descriptor word 3, signed element increments
  typedef struct packed {
    logic [7:0] yd;
    logic [7:0] ys;
    logic [7:0] xd;
    logic [7:0] xs;
  } dcae_inc_s;

  // progress of a channel, saved across preemption
  typedef struct packed {
    logic [31:0] src;
    logic [31:0] dst;
    logic [31:0] src_row;
    logic [31:0] dst_row;
    logic [7:0]  x_idx;
    logic [7:0]  y_idx;
  } dcae_ctx_s;

  // bus master request
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        we;
    logic [1:0]  size;
    logic        buff;
  } dcae_mreq_s;

  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH, ST_SETUP, ST_RDREQ, ST_RD, ST_WR, ST_DONE
  } dcae_state_e;

endpackage

/* logic/dcae_ctx_mem.sv */
`timescale 1ns/1ns
module dcae_ctx_mem
  import dcae_pkg::*;
(
  // clock and reset
  input  wire logic           core_clk_i,
  input  wire logic           resetn_i,
  // write port
  input  wire logic           we_i,
  input  wire logic [CHW-1:0] waddr_i,
  input  wire dcae_ctx_s      wdata_i,
  // read port
  input  wire logic [CHW-1:0] raddr_i,
  output dcae_ctx_s           rdata_o
);

  dcae_ctx_s mem_r [NCH];

  // storage has no reset; a slot is only read after it was written
  always_ff @(posedge core_clk_i) begin
    if (we_i) begin
      mem_r[waddr_i] <= wdata_i;
    end
  end

  // registered read
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem_r[raddr_i];
    end
  end

endmodule

/* logic/dcae_arbiter.sv */
`timescale 1ns/1ns
module dcae_arbiter
  import dcae_pkg::*;
(
  // clock and reset
  input  wire logic                 core_clk_i,
  input  wire logic                 resetn_i,
  // requests
  input  wire logic [NCH-1:0]       req_i,
  input  wire logic [NCH-1:0][1:0]  prio_i,
  // grant taken
  input  wire logic                 adv_i,
  // registered winner
  output logic                      win_v_o,
  output logic      [CHW-1:0]       win_i_o,
  output logic      [1:0]           win_p_o
);

  logic [CHW-1:0] ptr_r;
  logic [CHW-1:0] idx;
  logic           best_v;
  logic [CHW-1:0] best_i;
  logic [1:0]     best_p;

  // scan from the slot after the last grant; strict compare keeps the first tie
  always_comb begin
    best_v = 1'b0;
    best_i = '0;
    best_p = 2'h3;
    idx    = '0;
    for (int k = 1; k <= NCH; k++) begin
      idx = ptr_r + CHW'(k);
      // R01: smallest value wins
      // R03: round robin ties
      if (req_i[idx] && (!best_v || prio_i[idx] < best_p)) begin
        best_v = 1'b1;
        best_i = idx;
        best_p = prio_i[idx];
      end
    end
  end

  // winner is registered, one cycle behind the request lines
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      win_v_o <= 1'b0;
      win_i_o <= '0;
      win_p_o <= 2'h3;
    end else begin
      win_v_o <= best_v;
      win_i_o <= best_i;
      win_p_o <= best_p;
    end
  end

  // round robin pointer follows the last taken grant
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ptr_r <= CHW'(NCH - 1);
    end else if (adv_i) begin
      ptr_r <= win_i_o;
    end
  end

endmodule

/* logic/dcae_engine.sv */
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ns
// Functional notes
// R01: among pending channels the smallest priority value becomes active
// R02: each channel priority has exactly four levels, 0 to 3
// R03: equal winning priorities are served round robin
// R04: non-preemptable active channel runs its transfer to the end
// R05: preemptable channel yields after current element, returns to pending
// R06: one atomic transfer is one element of the configured width
// R07: preempted channel resumes only after the preemptor has completed
// R08: progress is saved at every preemption and restored on resume
// R09: width sets access size and the byte unit of loop increments
// R10: software selects 32-bit width toward peripheral registers
// R11: memory sides accept byte, halfword and word accesses
// R12: wide source into narrow destination keeps only the low bits
// R13: channel runs only with its own enable and the engine enable
// R14: software builds descriptors and indexes them before enabling
// R15: x and y counts of one move a single element
// R16: priority, preemptable and bufferable are held per channel
// R17: chained descriptor is taken up on completion when chaining is set
// R18: on activation the descriptor is fetched before any data moves
// R19: each channel has trigger in, trigger out and interrupt lines
// R20: single, x-loop and y-loop transfers come from the descriptor
// R21: one active channel; other triggers only mark pending
// R22: arbitration reruns on completion and on preemptable boundaries
module dcae_engine
  import dcae_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              resetn_i,
  // apb slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [11:0]       paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // bus master
  output logic                   m_valid_o,
  output dcae_mreq_s             m_req_o,
  input  wire logic              m_ready_i,
  input  wire logic [31:0]       m_rdata_i,
  // per-channel lines
  input  wire logic [NCH-1:0]    tr_in_i,
  output logic      [NCH-1:0]    tr_out_o,
  output logic      [NCH-1:0]    irq_o
);

  logic                 glob_en_r;
  logic [31:0]          dbase_r;
  dcae_chcfg_s          cfg_r [NCH];
  logic [NCH-1:0]       pend_r;
  logic [NCH-1:0]       resume_r;
  dcae_state_e          st_r;
  logic [CHW-1:0]       act_r;
  logic [1:0]           fidx_r;
  dcae_desc_s           desc_r;
  dcae_inc_s            inc_r;
  dcae_ctx_s            cur_r;
  dcae_ctx_s            nxt_ctx;
  dcae_ctx_s            ctx_rd;
  logic [NCH-1:0]       ch_en;
  logic [NCH-1:0][1:0]  ch_prio;
  logic [NCH-1:0]       arb_req;
  logic                 win_v;
  logic [CHW-1:0]       win_i;
  logic [1:0]           win_p;
  logic                 act_take;
  logic                 last_x;
  logic                 last_el;
  logic                 preempt_hit;
  logic                 preempt_go;
  logic                 chain_go;
  logic                 setup_ph;
  logic                 wr_acc;
  logic                 ch_hit;
  logic [CHW-1:0]       ch_sel;
  logic [31:0]          rd_nxt;
  logic                 rd_err;
  logic [31:0]          status;
  logic [31:0]          src_data;

  // element increment in bytes: signed element count scaled by width
  function automatic logic [31:0] step(input logic [7:0] inc, input logic [1:0] w);
    logic [31:0] s;
    s = {{24{inc[7]}}, inc};
    case (w)
      W_BYTE:  step = s;
      W_HALF:  step = {s[30:0], 1'b0};
      default: step = {s[29:0], 2'h0};
    endcase
  endfunction

  // keep only the bits of one element
  function automatic logic [31:0] trim(input logic [31:0] d, input logic [1:0] w);
    case (w)
      W_BYTE:  trim = {24'h00_0000, d[7:0]};
      W_HALF:  trim = {16'h0000, d[15:0]};
      default: trim = d;
    endcase
  endfunction

  // per-channel fields flattened for the arbiter
  generate
    for (genvar g = 0; g < NCH; g++) begin : g_ch
      assign ch_en[g]   = cfg_r[g].en;
      // R02: two-bit level
      assign ch_prio[g] = cfg_r[g].prio;
    end
  endgenerate

  // R13: both enables needed
  assign arb_req = pend_r & ch_en & {NCH{glob_en_r}};

  dcae_arbiter u_arb (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .req_i      (arb_req),
    .prio_i     (ch_prio),
    .adv_i      (act_take),
    .win_v_o    (win_v),
    .win_i_o    (win_i),
    .win_p_o    (win_p)
  );

  // next position after one element; y step restarts from the row base
  always_comb begin
    nxt_ctx = cur_r;
    last_x  = (cur_r.x_idx == desc_r.x_last);
    // R15: zero last-index fields mean one element
    last_el = last_x && (cur_r.y_idx == desc_r.y_last);
    // R09: increments in element units
    // R20: x loop inside y loop
    if (!last_x) begin
      nxt_ctx.src   = cur_r.src + step(inc_r.xs, desc_r.src_w);
      nxt_ctx.dst   = cur_r.dst + step(inc_r.xd, desc_r.dst_w);
      nxt_ctx.x_idx = cur_r.x_idx + 8'h01;
    end else begin
      nxt_ctx.src_row = cur_r.src_row + step(inc_r.ys, desc_r.src_w);
      nxt_ctx.dst_row = cur_r.dst_row + step(inc_r.yd, desc_r.dst_w);
      nxt_ctx.src     = nxt_ctx.src_row;
      nxt_ctx.dst     = nxt_ctx.dst_row;
      nxt_ctx.x_idx   = 8'h00;
      nxt_ctx.y_idx   = cur_r.y_idx + 8'h01;
    end
  end

  // boundary events; winner is strictly more urgent than the active channel
  // R04: needs the preemptable flag
  // R22: checked at every element end except the last
  assign preempt_hit = cfg_r[act_r].pre && win_v && (win_p < cfg_r[act_r].prio);
  assign preempt_go  = (st_r == ST_WR) && m_ready_i && !last_el && preempt_hit;
  assign chain_go    = (st_r == ST_DONE) && desc_r.chain;
  // R21: only from idle
  assign act_take    = (st_r == ST_IDLE) && win_v;
  assign src_data    = trim(m_rdata_i, desc_r.src_w);

  // R08: progress saved on preemption
  dcae_ctx_mem u_ctx (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .we_i       (preempt_go),
    .waddr_i    (act_r),
    .wdata_i    (nxt_ctx),
    .raddr_i    (act_r),
    .rdata_o    (ctx_rd)
  );

  // transfer sequencer and bus master
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r      <= ST_IDLE;
      act_r     <= '0;
      fidx_r    <= 2'h0;
      desc_r    <= '0;
      inc_r     <= '0;
      cur_r     <= '0;
      resume_r  <= '0;
      m_valid_o <= 1'b0;
      m_req_o   <= '0;
      tr_out_o  <= '0;
      irq_o     <= '0;
    end else begin
      tr_out_o <= '0;
      irq_o    <= '0;
      case (st_r)
        ST_IDLE: begin
          if (win_v) begin
            // R18: descriptor fetch first
            act_r          <= win_i;
            fidx_r         <= 2'h0;
            m_valid_o      <= 1'b1;
            m_req_o.addr   <= dbase_r + {20'h0_0000, cfg_r[win_i].idx, 4'h0};
            m_req_o.wdata  <= '0;
            m_req_o.we     <= 1'b0;
            m_req_o.size   <= W_WORD;
            m_req_o.buff   <= cfg_r[win_i].buff;
            st_r           <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (m_ready_i) begin
            case (fidx_r)
              2'h0: begin
                desc_r      <= m_rdata_i;
                cur_r.x_idx <= 8'h00;
                cur_r.y_idx <= 8'h00;
              end
              2'h1: begin
                cur_r.src     <= m_rdata_i;
                cur_r.src_row <= m_rdata_i;
              end
              2'h2: begin
                cur_r.dst     <= m_rdata_i;
                cur_r.dst_row <= m_rdata_i;
              end
              default: inc_r <= m_rdata_i;
            endcase
            fidx_r       <= fidx_r + 2'h1;
            m_req_o.addr <= m_req_o.addr + WORD_STEP;
            if (fidx_r == DESC_LAST_WORD) begin
              m_valid_o <= 1'b0;
              st_r      <= ST_SETUP;
            end
          end
        end
        ST_SETUP: begin
          // R07: a resumed channel picks up where it stopped
          if (resume_r[act_r]) begin
            cur_r <= ctx_rd;
          end
          resume_r[act_r] <= 1'b0;
          st_r            <= ST_RDREQ;
        end
        ST_RDREQ: begin
          // R11: access size from the width code
          m_valid_o    <= 1'b1;
          m_req_o.addr <= cur_r.src;
          m_req_o.we   <= 1'b0;
          m_req_o.size <= desc_r.src_w;
          st_r         <= ST_RD;
        end
        ST_RD: begin
          if (m_ready_i) begin
            // R12: narrow destination drops the upper bits
            m_req_o.addr  <= cur_r.dst;
            m_req_o.we    <= 1'b1;
            m_req_o.size  <= desc_r.dst_w;
            m_req_o.wdata <= trim(src_data, desc_r.dst_w);
            st_r          <= ST_WR;
          end
        end
        ST_WR: begin
          if (m_ready_i) begin
            m_valid_o <= 1'b0;
            // R06: boundary after each element
            if (last_el) begin
              st_r <= ST_DONE;
            end else if (preempt_hit) begin
              // R05: yield and go back to pending
              resume_r[act_r] <= 1'b1;
              st_r            <= ST_IDLE;
            end else begin
              cur_r <= nxt_ctx;
              st_r  <= ST_RDREQ;
            end
          end
        end
        ST_DONE: begin
          // R19: completion pulses per channel
          tr_out_o[act_r] <= 1'b1;
          irq_o[act_r]    <= 1'b1;
          st_r            <= ST_IDLE;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // pending flags; a new trigger in the clearing cycle survives
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pend_r <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        // R21: triggers only mark pending
        if (tr_in_i[c] || (wr_acc && paddr_i == A_SWTRIG && pwdata_i[c])) begin
          pend_r[c] <= 1'b1;
        end else if ((preempt_go || chain_go) && act_r == CHW'(c)) begin
          pend_r[c] <= 1'b1;
        end else if (act_take && win_i == CHW'(c)) begin
          pend_r[c] <= 1'b0;
        end
      end
    end
  end

  // apb decode
  assign setup_ph = psel_i && !penable_i;
  assign wr_acc   = psel_i && penable_i && pwrite_i && pready_o;
  assign ch_hit   = (paddr_i[11:5] == A_CHCFG[11:5]) && (paddr_i[1:0] == 2'h0);
  assign ch_sel   = paddr_i[4:2];

  // status view
  always_comb begin
    status = '0;
    status[STA_BSY_BIT]               = (st_r != ST_IDLE);
    status[STA_ACT_LSB +: CHW]        = act_r;
    status[STA_PND_LSB +: NCH]        = pend_r;
    status[STA_RES_LSB +: NCH]        = resume_r;
  end

  // read data and error for the access about to start
  always_comb begin
    rd_nxt = '0;
    rd_err = 1'b0;
    if (ch_hit) begin
      rd_nxt[CFG_EN_BIT]       = cfg_r[ch_sel].en;
      rd_nxt[CFG_PRI_LSB +: 2] = cfg_r[ch_sel].prio;
      rd_nxt[CFG_PRE_BIT]      = cfg_r[ch_sel].pre;
      rd_nxt[CFG_BUF_BIT]      = cfg_r[ch_sel].buff;
      rd_nxt[CFG_IDX_LSB +: 8] = cfg_r[ch_sel].idx;
    end else begin
      case (paddr_i)
        A_CTRL:   rd_nxt[CTRL_EN_BIT] = glob_en_r;
        A_STATUS: rd_nxt = status;
        A_DBASE:  rd_nxt = dbase_r;
        A_SWTRIG: rd_nxt = '0;
        default:  rd_err = 1'b1;
      endcase
    end
  end

  // one wait-free access phase; outputs are registered at setup
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= '0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= setup_ph;
      pslverr_o <= setup_ph && rd_err;
      prdata_o  <= (setup_ph && !pwrite_i) ? rd_nxt : 32'h0000_0000;
    end
  end

  // software registers; chaining moves the channel to its next descriptor
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      glob_en_r <= CTRL_RST;
      dbase_r   <= DBASE_RST;
      for (int c = 0; c < NCH; c++) begin
        cfg_r[c] <= '0;
      end
    end else begin
      // R17: chained descriptor index
      if (chain_go) begin
        cfg_r[act_r].idx <= desc_r.next_desc_index;
      end
      if (wr_acc && !pslverr_o) begin
        if (ch_hit) begin
          // R16: independent per channel
          cfg_r[ch_sel].en   <= pwdata_i[CFG_EN_BIT];
          cfg_r[ch_sel].prio <= pwdata_i[CFG_PRI_LSB +: 2];
          cfg_r[ch_sel].pre  <= pwdata_i[CFG_PRE_BIT];
          cfg_r[ch_sel].buff <= pwdata_i[CFG_BUF_BIT];
          cfg_r[ch_sel].idx  <= pwdata_i[CFG_IDX_LSB +: 8];
        end else if (paddr_i == A_CTRL) begin
          glob_en_r <= pwdata_i[CTRL_EN_BIT];
        end else if (paddr_i == A_DBASE) begin
          dbase_r <= pwdata_i;
        end
      end
    end
  end

endmodule

/* bench/dcae_chk.sv */
`timescale 1ns/1ns
module dcae_chk
  import dcae_pkg::*;
(
  // clock and reset
  input wire logic           core_clk_i,
  input wire logic           resetn_i,
  // apb side
  input wire logic           psel_i,
  input wire logic           penable_i,
  input wire logic           pwrite_i,
  input wire logic [11:0]    paddr_i,
  input wire logic [31:0]    pwdata_i,
  input wire logic           pready_o,
  input wire logic           pslverr_o,
  // bus master side
  input wire logic           m_valid_o,
  input wire dcae_mreq_s     m_req_o,
  input wire logic           m_ready_i,
  // channel lines
  input wire logic [NCH-1:0] tr_out_o,
  input wire logic [NCH-1:0] irq_o
);
  logic en_r, rdacc_r, wr_r, wacc_r;

  // shadow of engine enable, updated on the same edge as the register, and of bus phases, one cycle late
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      en_r    <= 1'b0;
      rdacc_r <= 1'b0;
      wr_r    <= 1'b0;
      wacc_r  <= 1'b0;
    end else begin
      if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == A_CTRL) begin
        en_r <= pwdata_i[CTRL_EN_BIT];
      end
      rdacc_r <= m_valid_o && m_ready_i && !m_req_o.we;
      wr_r    <= m_valid_o && m_req_o.we;
      wacc_r  <= m_valid_o && m_ready_i && m_req_o.we;
    end
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  // completion is a single-cycle pulse
  sequence s_pulse;
    (tr_out_o != 8'h00) ##1 (tr_out_o == 8'h00);
  endsequence

  AST_REQ_HOLD: assert property (m_valid_o && !m_ready_i |=> m_valid_o && $stable(m_req_o))
    else $error("request moved early");
  AST_RD_BEFORE_WR: assert property (m_valid_o && m_req_o.we && !wr_r |-> rdacc_r)
    else $error("write without read");
  AST_DONE_AFTER_WR: assert property (tr_out_o != 8'h00 |-> $past(wacc_r))
    else $error("done without write");
  AST_DONE_PULSE: assert property (tr_out_o != 8'h00 |-> irq_o == tr_out_o ##0 s_pulse)
    else $error("bad done pulse");
  AST_ONE_DONE: assert property ($onehot0(tr_out_o))
    else $error("two done at once");
  AST_APB_READY: assert property (psel_i && !penable_i |=> pready_o ##1 !pready_o)
    else $error("late register answer");
  AST_SLVERR: assert property (psel_i && !penable_i && paddr_i[11:6] != 6'h00
    |=> pready_o && pslverr_o)
    else $error("unmapped not refused");
  AST_ENGINE_OFF: assert property (!en_r && !m_valid_o |=> !m_valid_o)
    else $error("busy while disabled");
  AST_BYTE_TRIM: assert property (m_valid_o && m_req_o.we && m_req_o.size == W_BYTE
    |-> m_req_o.wdata[31:8] == 24'h000000)
    else $error("byte upper bits set");
  AST_HALF_TRIM: assert property (m_valid_o && m_req_o.we && m_req_o.size == W_HALF
    |-> m_req_o.wdata[31:16] == 16'h0000)
    else $error("half upper bits set");
endmodule

bind dcae_engine dcae_chk u_chk (
  .core_clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o,
  .pslverr_o, .m_valid_o, .m_req_o, .m_ready_i, .tr_out_o, .irq_o
);

/* bench/dcae_mem.sv */
`timescale 1ns/1ns
module dcae_mem
  import dcae_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  // wait-state control
  input  wire logic        slow_i,
  // bus from the engine
  input  wire logic        m_valid_i,
  input  wire dcae_mreq_s  m_req_i,
  output logic             m_ready_o,
  output logic      [31:0] m_rdata_o
);
  logic [7:0]  mem [0:4095];
  logic [2:0]  wt_r;
  logic [31:0] rd;
  int          nb;

  // bytes moved per access
  assign nb = (m_req_i.size == W_BYTE) ? 1 : (m_req_i.size == W_HALF) ? 2 : 4;

  // random waits; junk in idle cycles and unused lanes
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      m_ready_o <= 1'b0;
      m_rdata_o <= 32'hA5A5_5A5A;
      wt_r      <= 3'h0;
    end else if (m_ready_o) begin
      if (m_req_i.we) begin
        for (int i = 0; i < nb; i++) mem[m_req_i.addr[11:0] + 12'(i)] <= m_req_i.wdata[8*i +: 8];
      end
      m_ready_o <= 1'b0;
      m_rdata_o <= ~m_rdata_o;
      wt_r      <= slow_i ? 3'($urandom % 4) : 3'h0;
    end else if (m_valid_i && wt_r == 3'h0) begin
      rd = $urandom;
      for (int i = 0; i < nb; i++) rd[8*i +: 8] = mem[m_req_i.addr[11:0] + 12'(i)];
      m_ready_o <= 1'b1;
      m_rdata_o <= rd;
    end else begin
      wt_r      <= (wt_r != 3'h0) ? wt_r - 3'h1 : 3'h0;
      m_rdata_o <= ~m_rdata_o;
    end
  end
endmodule

/* bench/testbench.sv */
`timescale 1ns/1ns
module testbench
  import dcae_pkg::*;
  ;
  logic             clk, rst_n, psel, pen, pwr, slow, prdy, perr, mval, mrdy;
  logic      [11:0] paddr;
  logic      [31:0] pwdata, prdata, mrdata;
  logic      [7:0]  trin, trout, irq;
  dcae_mreq_s       mreq;
  logic      [7:0]  sh [0:4095];
  logic      [31:0] rq [$];
  logic      [7:0]  dq [$];
  int               num_errors = 0, tests_run = 0, cyc = 0;
  // width cases: word to byte, half y-loop, single byte, chained word
  logic      [1:0]  sw_t [4] = '{W_WORD, W_HALF, W_BYTE, W_WORD};
  logic      [1:0]  dw_t [4] = '{W_BYTE, W_HALF, W_BYTE, W_WORD};
  int               xn_t [4] = '{4, 3, 1, 2};
  int               yn_t [4] = '{1, 2, 1, 1};
  logic      [31:0] in_t [4] = '{32'h100, 32'h0404_0101, 32'h101, 32'h101};

  dcae_engine DUT (
    .core_clk_i(clk), .resetn_i(rst_n), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(prdy), .pslverr_o(perr),
    .m_valid_o(mval), .m_req_o(mreq), .m_ready_i(mrdy), .m_rdata_i(mrdata),
    .tr_in_i(trin), .tr_out_o(trout), .irq_o(irq)
  );
  dcae_mem MEM (
    .core_clk_i(clk), .resetn_i(rst_n), .slow_i(slow), .m_valid_i(mval), .m_req_i(mreq),
    .m_ready_o(mrdy), .m_rdata_o(mrdata)
  );

  // clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic cmp(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task conclude;
    $display("errors=%0d tests_run=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // notes against read answers and completions; hang guard
  always @(posedge clk) begin
    cyc++;
    if (rst_n && prdy && !pwr) cmp(prdata, rq.pop_front());
    if (rst_n && trout != 8'h00) cmp({24'h0, trout}, {24'h0, dq.size() ? dq.pop_front() : 8'h00});
    if (cyc == 30000) begin
      num_errors++;
      conclude;
    end
  end

  // one apb transfer, held until pready is sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    if (!w) rq.push_back(d);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= w ? d : $urandom;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk iff prdy);
    psel <= 1'b0;
    pen  <= 1'b0;
    @(posedge clk);
  endtask

  task automatic setch(input int c, input logic en, input logic [1:0] p, input logic pr,
                       input logic [7:0] ix);
    logic [31:0] v;
    v = {16'h0, ix, 3'h0, 1'($urandom), pr, p, en};
    apb(1'b1, A_CHCFG + 12'(4 * c), v);
    apb(1'b0, A_CHCFG + 12'(4 * c), v);
  endtask

  task automatic put(input int a, input logic [31:0] v);
    for (int i = 0; i < 4; i++) begin
      MEM.mem[a + i] = v[8*i +: 8];
      sh[a + i]      = v[8*i +: 8];
    end
  endtask

  // descriptor into memory, expected copy into the shadow
  task automatic desc(input int ix, input logic [1:0] sw, dw, input logic ch, input int xn, yn,
                      input int src, dst, input logic [31:0] inc);
    int          sa, da;
    logic [31:0] v;
    put(256 + 16 * ix, {8'(yn - 1), 8'(xn - 1), 8'h05, 3'h0, ch, dw, sw});
    put(260 + 16 * ix, src);
    put(264 + 16 * ix, dst);
    put(268 + 16 * ix, inc);
    for (int y = 0; y < yn; y++) begin
      for (int x = 0; x < xn; x++) begin
        sa = src + (y * inc[23:16] + x * inc[7:0]) * (1 << sw);
        da = dst + (y * inc[31:24] + x * inc[15:8]) * (1 << dw);
        v  = 32'h0;
        for (int i = 0; i < (1 << sw); i++) v[8*i +: 8] = sh[sa + i];
        for (int i = 0; i < (1 << dw); i++) sh[da + i] = v[8*i +: 8];
      end
    end
  endtask

  task automatic trig(input logic [7:0] m);
    trin <= m;
    @(posedge clk);
    trin <= 8'h00;
    @(posedge clk);
  endtask

  task automatic drain(input int left);
    while (dq.size() > left) @(posedge clk);
    repeat (4) @(posedge clk);
  endtask

  initial begin
    void'($urandom(32'h587265df));
    {psel, pen, pwr, paddr, pwdata, trin, rst_n} = '0;
    slow = 1'b1;
    for (int a = 0; a < 4096; a += 4) put(a, $urandom);
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // reset values, refused and write-only places
    for (int a = 0; a <= 'h10; a += 4) apb(1'b0, 12'(a), (12'(a) == A_DBASE) ? DBASE_RST : 32'h0);
    apb(1'b1, 12'h040, 32'hFFFF_FFFF);
    apb(1'b0, 12'h040, 32'h0);
    apb(1'b1, A_DBASE, 32'h0000_0100);
    apb(1'b0, A_DBASE, 32'h0000_0100);
    // channel enable alone stays quiet
    setch(7, 1'b1, 2'h3, 1'b0, 8'h07);
    trig(8'h80);
    repeat (40) @(posedge clk);
    setch(7, 1'b0, 2'h3, 1'b0, 8'h07);
    apb(1'b1, A_CTRL, 32'h1);
    // widths, single element, y-loop and chaining on channel 0
    for (int k = 0; k < 4; k++) begin
      slow <= 1'($urandom);
      desc(k, sw_t[k], dw_t[k], k == 3, xn_t[k], yn_t[k], 'h400 + 'h100 * k, 'h800 + 'h100 * k,
           in_t[k]);
      setch(0, 1'b1, 2'($urandom), 1'b0, 8'(k));
      dq.push_back(8'h01);
      if (k == 3) begin
        desc(5, W_HALF, W_BYTE, 1'b0, 2, 1, 'h500, 'hB80, 32'h101);
        dq.push_back(8'h01);
      end
      if (k[0]) apb(1'b1, A_SWTRIG, 32'h1);
      else trig(8'h01);
      drain(0);
    end
    // long non-preemptable run, then more urgent levels, two of them equal, queue behind it
    slow <= 1'b1;
    desc(11, W_WORD, W_WORD, 1'b0, 16, 1, 'h400, 'hC00, 32'h101);
    for (int i = 0; i < 3; i++)
      desc(8 + i, W_BYTE, W_BYTE, 1'b0, 2, 1, 'h440 + 16 * i, 'hD00 + 64 * i, 32'h101);
    setch(3, 1'b1, 2'h3, 1'b0, 8'd11);
    setch(5, 1'b1, 2'h0, 1'b0, 8'd8);
    setch(1, 1'b1, 2'h0, 1'b0, 8'd9);
    setch(0, 1'b1, 2'h2, 1'b0, 8'd10);
    dq = '{8'h08, 8'h20, 8'h02, 8'h01};
    trig(8'h08);
    repeat (30) @(posedge clk);
    trig(8'h23);
    drain(0);
    // preemptable run interrupted twice by a higher level
    desc(14, W_WORD, W_WORD, 1'b0, 32, 1, 'h400, 'hE00, 32'h101);
    desc(10, W_HALF, W_HALF, 1'b0, 2, 1, 'h480, 'hF00, 32'h101);
    setch(6, 1'b1, 2'h3, 1'b1, 8'd14);
    setch(2, 1'b1, 2'h1, 1'b0, 8'd10);
    dq = '{8'h04, 8'h04, 8'h40};
    trig(8'h40);
    repeat (30) @(posedge clk);
    trig(8'h04);
    drain(2);
    trig(8'h04);
    drain(0);
    for (int a = 'h800; a < 4096; a++) cmp({24'h0, MEM.mem[a]}, {24'h0, sh[a]});
    cmp(32'(dq.size()), 32'h0);
    conclude;
  end
endmodule
